// ### flash_iap_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * in-application flash controller.
 * Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
 */
`ifndef FLASH_IAP_MAP_SVH
`define FLASH_IAP_MAP_SVH

`define FIAP_CTRL_OFS 8'h00
`define FIAP_ADDRL_OFS 8'h04
`define FIAP_ADDRH_OFS 8'h08
`define FIAP_DATAL_OFS 8'h0c
`define FIAP_DATAH_OFS 8'h10
`define FIAP_KEY1_OFS 8'h14
`define FIAP_KEY2_OFS 8'h18
`define FIAP_KEY3_OFS 8'h1c
`define FIAP_IRQ_STATUS_OFS 8'h20
`define FIAP_IRQ_MASK_OFS 8'h24

`define FIAP_CTRL_MODE_LSB 0
`define FIAP_CTRL_RDEN_BIT 3
`define FIAP_CTRL_RDTRIG_BIT 4
`define FIAP_CTRL_EWTRIG_BIT 5
`define FIAP_CTRL_UNLOCK_BIT 6
`define FIAP_CTRL_EWEN_BIT 7
`define FIAP_CTRL_BUFCLR_BIT 8

`define FIAP_IRQ_READ_DONE 0
`define FIAP_IRQ_EW_DONE 1
`define FIAP_IRQ_UNLOCK_DONE 2

`define FIAP_MODE_WRITE 3'h0
`define FIAP_MODE_ERASE 3'h1
`define FIAP_MODE_READ 3'h3
`define FIAP_MODE_UNLOCK 3'h6
`define FIAP_MODE_RESET 3'h0

`define FIAP_KEY1 16'h0400
`define FIAP_KEY2 16'h090d
`define FIAP_KEY3 16'h40c3

`define FIAP_READ_INSTR_CYCLES 3
`define FIAP_CLKS_PER_INSTR 4
`define FIAP_READ_CLKS (`FIAP_READ_INSTR_CYCLES * `FIAP_CLKS_PER_INSTR)
`define FIAP_EW_CLKS_DEFAULT 4000
`define FIAP_UNLOCK_CLKS_DEFAULT 2000

`define FIAP_RESP_OKAY 2'h0
`define FIAP_RESP_SLVERR 2'h2

`endif

// ### flash_iap_pkg.sv
/*
 * Types of the in-application flash controller: sequencer states and the
 * packed state record of the controller.
 * Assumes a 13-bit word address and 32-word pages.
 */
package flash_iap_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_READ = 5'h02,
		ST_ERASE = 5'h04,
		ST_PROG = 5'h08,
		ST_WAIT = 5'h10
	} seq_e;

	typedef struct packed {
		seq_e fsm;
		logic [2:0] opMode;
		logic readEnable;
		logic readTrigger;
		logic ewTrigger;
		logic unlockRequest;
		logic ewEnabled;
		logic [12:0] addr;
		logic [15:0] dataOut;
		logic [7:0] dataLowIn;
		logic [15:0] key1;
		logic [15:0] key2;
		logic [15:0] key3;
		logic [31:0][15:0] wrBuf;
		logic [31:0] wrBufValid;
		logic [4:0] bufPtr;
		logic [4:0] progIdx;
		logic [15:0] count;
		logic [15:0] unlockCount;
		logic [2:0] irqStatus;
		logic [2:0] irqMask;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} ctl_state_s;

endpackage : flash_iap_pkg

// ### flash_iap_read_write_control.sv
/*
 * In-application flash controller: unlock, page erase, page write through a
 * 32-word write buffer, and word read, all driven over AXI4-Lite registers.
 * Assumes a flash array that returns read data within the read window and
 * accepts one-cycle erase and program strobes.
 */
`timescale 1ns/1ps
`include "flash_iap_map.svh"

// Functional notes
// - erase or write starts only while the erase/write enabled flag is set.
// - erase always clears the whole page chosen by the upper address bits.
// - write programs the loaded buffer words into one page, never crossing the page.
// - setting the buffer clear bit empties the entire write buffer.
// - a rewrite of the same page is accepted without a fresh erase.
// - reads happen only in read mode with the read enable bit set.
// - software loads the address, then sets the read trigger to start.
// - on completion data lands in the data registers, trigger clears.
// - reads need no unlock.
// - the CPU is held stalled while a read runs.
// - read trigger drops three instruction cycles after the read starts.
// - mode selects erase or write; the trigger starts it and self-clears.
// - buffer pointer advances on each high data write in write mode, stops at word 31.
// - unlock mode plus unlock bit starts a timer; key match enables.
// - the programmed page is the one selected by the upper address bits.
module flash_iap_read_write_control import flash_iap_pkg::*; #(
	parameter int EW_CLKS = `FIAP_EW_CLKS_DEFAULT,
	parameter int UNLOCK_CLKS = `FIAP_UNLOCK_CLKS_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [12:0] memAddr,
	output logic memReadReq,
	input wire logic [15:0] memReadData,
	output logic memEraseReq,
	output logic memProgReq,
	output logic [15:0] memProgData,
	output logic cpuStall,
	output logic irq
);

	localparam logic [15:0] READ_COUNT = 16'(`FIAP_READ_CLKS);
	localparam logic [15:0] EW_COUNT = 16'(EW_CLKS);
	localparam logic [15:0] UNLOCK_COUNT = 16'(UNLOCK_CLKS);

	if (EW_CLKS < 1 || EW_CLKS > 65535) begin : badEwClks
		$error("EW_CLKS out of range");
	end
	if (UNLOCK_CLKS < 1 || UNLOCK_CLKS > 65535) begin : badUnlockClks
		$error("UNLOCK_CLKS out of range");
	end

	function automatic logic [12:0] pageBase(input logic [12:0] a);
		pageBase = {a[12:5], 5'h00};
	endfunction : pageBase

	function automatic logic isMapped(input logic [7:0] a);
		unique case ({a[7:2], 2'b00})
			`FIAP_CTRL_OFS, `FIAP_ADDRL_OFS, `FIAP_ADDRH_OFS, `FIAP_DATAL_OFS,
			`FIAP_DATAH_OFS, `FIAP_KEY1_OFS, `FIAP_KEY2_OFS, `FIAP_KEY3_OFS,
			`FIAP_IRQ_STATUS_OFS, `FIAP_IRQ_MASK_OFS: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction : isMapped

	ctl_state_s st;
	ctl_state_s next_st;

	logic wrFire;
	logic rdFire;
	logic [7:0] wrOfs;
	logic [7:0] rdOfs;
	logic busy;
	logic [2:0] events;
	logic [31:0] ctrlView;

	assign wrFire = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
	assign rdFire = s_axi_arvalid && !st.rvalid;
	assign wrOfs = {s_axi_awaddr[7:2], 2'b00};
	assign rdOfs = {s_axi_araddr[7:2], 2'b00};
	assign busy = (st.fsm != ST_IDLE);

	// the bus slave must keep answering while the CPU core is stalled
	assign s_axi_awready = wrFire;
	assign s_axi_wready = wrFire;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = rdFire;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;

	assign cpuStall = busy;
	assign irq = |(st.irqStatus & st.irqMask);
	assign memReadReq = (st.fsm == ST_READ);
	assign memEraseReq = (st.fsm == ST_ERASE);
	assign memProgReq = (st.fsm == ST_PROG) && st.wrBufValid[st.progIdx];
	assign memProgData = st.wrBuf[st.progIdx];

	always_comb begin
		unique case (st.fsm)
			ST_ERASE: memAddr = pageBase(st.addr);
			ST_PROG: memAddr = {st.addr[12:5], st.progIdx};
			default: memAddr = st.addr;
		endcase
	end

	always_comb begin
		ctrlView = 32'h0;
		ctrlView[`FIAP_CTRL_MODE_LSB +: 3] = st.opMode;
		ctrlView[`FIAP_CTRL_RDEN_BIT] = st.readEnable;
		ctrlView[`FIAP_CTRL_RDTRIG_BIT] = st.readTrigger;
		ctrlView[`FIAP_CTRL_EWTRIG_BIT] = st.ewTrigger;
		ctrlView[`FIAP_CTRL_UNLOCK_BIT] = st.unlockRequest;
		ctrlView[`FIAP_CTRL_EWEN_BIT] = st.ewEnabled;
	end

	always_comb begin
		next_st = st;
		events = 3'h0;

		// register writes
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wrFire) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = isMapped(s_axi_awaddr) ? `FIAP_RESP_OKAY : `FIAP_RESP_SLVERR;
			if (s_axi_wstrb[0]) begin
				unique case (wrOfs)
					`FIAP_CTRL_OFS: begin
						if (!busy) begin
							next_st.opMode = s_axi_wdata[`FIAP_CTRL_MODE_LSB +: 3];
							next_st.readEnable = s_axi_wdata[`FIAP_CTRL_RDEN_BIT];
						end
						// software may only drop the enable; setting it takes the key
						if (!s_axi_wdata[`FIAP_CTRL_EWEN_BIT]) begin
							next_st.ewEnabled = 1'b0;
						end
						if (s_axi_wdata[`FIAP_CTRL_BUFCLR_BIT - 8 + 8] && s_axi_wstrb[1]
							&& !busy) begin
							next_st.wrBuf = '0;
							next_st.wrBufValid = 32'h0;
						end
						if (!busy && s_axi_wdata[`FIAP_CTRL_RDTRIG_BIT]
							&& s_axi_wdata[`FIAP_CTRL_MODE_LSB +: 3] == `FIAP_MODE_READ
							&& s_axi_wdata[`FIAP_CTRL_RDEN_BIT]) begin
							next_st.readTrigger = 1'b1;
							next_st.fsm = ST_READ;
							next_st.count = READ_COUNT;
						end else if (!busy && s_axi_wdata[`FIAP_CTRL_EWTRIG_BIT]
							&& st.ewEnabled) begin
							if (s_axi_wdata[`FIAP_CTRL_MODE_LSB +: 3] == `FIAP_MODE_ERASE) begin
								next_st.ewTrigger = 1'b1;
								next_st.fsm = ST_ERASE;
							end else if (s_axi_wdata[`FIAP_CTRL_MODE_LSB +: 3]
								== `FIAP_MODE_WRITE) begin
								// no erase check: a rewrite of the same page is allowed
								next_st.ewTrigger = 1'b1;
								next_st.fsm = ST_PROG;
								next_st.progIdx = 5'h00;
							end
						end
						if (!busy && !st.unlockRequest && s_axi_wdata[`FIAP_CTRL_UNLOCK_BIT]
							&& s_axi_wdata[`FIAP_CTRL_MODE_LSB +: 3] == `FIAP_MODE_UNLOCK) begin
							next_st.unlockRequest = 1'b1;
							next_st.unlockCount = UNLOCK_COUNT;
						end
					end
					`FIAP_ADDRL_OFS: begin
						if (!busy) begin
							next_st.addr[7:0] = s_axi_wdata[7:0];
							next_st.bufPtr = s_axi_wdata[4:0];
						end
					end
					`FIAP_ADDRH_OFS: begin
						if (!busy) begin
							next_st.addr[12:8] = s_axi_wdata[4:0];
						end
					end
					`FIAP_DATAL_OFS: next_st.dataLowIn = s_axi_wdata[7:0];
					`FIAP_DATAH_OFS: begin
						if (!busy && st.opMode == `FIAP_MODE_WRITE) begin
							next_st.wrBuf[st.bufPtr] = {s_axi_wdata[7:0], st.dataLowIn};
							next_st.wrBufValid[st.bufPtr] = 1'b1;
							if (st.bufPtr != 5'h1f) begin
								next_st.bufPtr = st.bufPtr + 5'h01;
							end
						end
					end
					`FIAP_KEY1_OFS: next_st.key1 = s_axi_wdata[15:0];
					`FIAP_KEY2_OFS: next_st.key2 = s_axi_wdata[15:0];
					`FIAP_KEY3_OFS: next_st.key3 = s_axi_wdata[15:0];
					`FIAP_IRQ_MASK_OFS: next_st.irqMask = s_axi_wdata[2:0];
					default: begin
					end
				endcase
			end
		end

		// register reads
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rdFire) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = isMapped(s_axi_araddr) ? `FIAP_RESP_OKAY : `FIAP_RESP_SLVERR;
			unique case (rdOfs)
				`FIAP_CTRL_OFS: next_st.rdata = ctrlView;
				`FIAP_ADDRL_OFS: next_st.rdata = {24'h0, st.addr[7:0]};
				`FIAP_ADDRH_OFS: next_st.rdata = {27'h0, st.addr[12:8]};
				`FIAP_DATAL_OFS: next_st.rdata = {24'h0, st.dataOut[7:0]};
				`FIAP_DATAH_OFS: next_st.rdata = {24'h0, st.dataOut[15:8]};
				`FIAP_KEY1_OFS: next_st.rdata = {16'h0, st.key1};
				`FIAP_KEY2_OFS: next_st.rdata = {16'h0, st.key2};
				`FIAP_KEY3_OFS: next_st.rdata = {16'h0, st.key3};
				`FIAP_IRQ_STATUS_OFS: next_st.rdata = {29'h0, st.irqStatus};
				`FIAP_IRQ_MASK_OFS: next_st.rdata = {29'h0, st.irqMask};
				default: next_st.rdata = 32'h0;
			endcase
		end

		// unlock timer runs beside the sequencer; the key is judged at timeout
		if (st.unlockRequest) begin
			next_st.unlockCount = st.unlockCount - 16'h0001;
			if (st.unlockCount == 16'h0001) begin
				next_st.unlockRequest = 1'b0;
				next_st.ewEnabled = (st.key1 == `FIAP_KEY1) && (st.key2 == `FIAP_KEY2)
					&& (st.key3 == `FIAP_KEY3);
				events[`FIAP_IRQ_UNLOCK_DONE] = 1'b1;
			end
		end

		// sequencer
		unique case (st.fsm)
			ST_IDLE: begin
			end
			ST_READ: begin
				next_st.count = st.count - 16'h0001;
				if (st.count == 16'h0001) begin
					next_st.dataOut = memReadData;
					next_st.readTrigger = 1'b0;
					next_st.fsm = ST_IDLE;
					events[`FIAP_IRQ_READ_DONE] = 1'b1;
				end
			end
			ST_ERASE: begin
				next_st.fsm = ST_WAIT;
				next_st.count = EW_COUNT;
			end
			ST_PROG: begin
				// every buffer slot is visited; only slots written since the last clear get a program strobe
				next_st.progIdx = st.progIdx + 5'h01;
				if (st.progIdx == 5'h1f) begin
					next_st.fsm = ST_WAIT;
					next_st.count = EW_COUNT;
				end
			end
			ST_WAIT: begin
				next_st.count = st.count - 16'h0001;
				if (st.count == 16'h0001) begin
					next_st.ewTrigger = 1'b0;
					next_st.fsm = ST_IDLE;
					events[`FIAP_IRQ_EW_DONE] = 1'b1;
				end
			end
			default: next_st.fsm = ST_IDLE;
		endcase

		// a same-cycle event beats a write-one clear
		if (wrFire && s_axi_wstrb[0] && wrOfs == `FIAP_IRQ_STATUS_OFS) begin
			next_st.irqStatus = st.irqStatus & ~s_axi_wdata[2:0];
		end
		next_st.irqStatus = next_st.irqStatus | events;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{fsm: ST_IDLE, opMode: `FIAP_MODE_RESET, default: '0};
		end else begin
			st <= next_st;
		end
	end

endmodule : flash_iap_read_write_control

// ### flash_iap_props.sv
/*
 * Concurrent checks on the flash controller ports: read window, stall, page erase/program.
 * Assumes one clock and the async active-low reset of the controller.
 */
`timescale 1ns/1ps
module flash_iap_props #(
	parameter int EW_CLKS = 4000,
	parameter int UNLOCK_CLKS = 2000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic [12:0] memAddr,
	input wire logic memReadReq,
	input wire logic memEraseReq,
	input wire logic memProgReq,
	input wire logic cpuStall
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence readHeld;
		memReadReq [*8] ##1 memReadReq [*4];
	endsequence
	a_read_window: assert property ($rose(memReadReq) |-> readHeld ##1 !memReadReq)
		else $error("read window length wrong");
	a_read_stall: assert property (memReadReq |-> cpuStall)
		else $error("cpu not stalled during read");
	a_read_alone: assert property (memReadReq |-> !memEraseReq && !memProgReq)
		else $error("read overlaps erase or program");
	a_erase_base: assert property (memEraseReq |-> memAddr[4:0] == 5'h00)
		else $error("erase not at page base");
	a_erase_pulse: assert property (memEraseReq |=> !memEraseReq && cpuStall)
		else $error("erase strobe too long or no stall");
	a_prog_stall: assert property (memProgReq |-> cpuStall)
		else $error("program without stall");
	a_prog_page: assert property (memProgReq && $past(memProgReq) |->
		memAddr[12:5] == $past(memAddr[12:5]))
		else $error("program walk left its page");
	a_bus_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write response late");
endmodule : flash_iap_props

bind flash_iap_read_write_control flash_iap_props #(.EW_CLKS(EW_CLKS),
	.UNLOCK_CLKS(UNLOCK_CLKS)) i_props (.clk(clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
	.memAddr(memAddr), .memReadReq(memReadReq), .memEraseReq(memEraseReq),
	.memProgReq(memProgReq), .cpuStall(cpuStall));

// ### flash_array_model.sv
/*
 * Behavioural flash program array: page erase to all ones, program clears bits only.
 * Assumes one-cycle erase and program strobes from the controller.
 */
`timescale 1ns/1ps
module flash_array_model (
	input wire logic clk,
	input wire logic [12:0] memAddr,
	input wire logic memReadReq,
	input wire logic memEraseReq,
	input wire logic memProgReq,
	input wire logic [15:0] memProgData,
	output logic [15:0] memReadData
);
	logic [15:0] mem [0:8191];
	initial for (int i = 0; i < 8192; i++) mem[i] = 16'h1234;
	always @(posedge clk) begin
		if (memEraseReq) begin
			for (int i = 0; i < 32; i++) mem[{memAddr[12:5], i[4:0]}] = 16'hffff;
		end
		// a rewrite without erase can only clear more bits
		if (memProgReq) mem[memAddr] = mem[memAddr] & memProgData;
	end
	// outside a read the bus shows the inverse, so a late sample cannot pass by luck
	assign memReadData = memReadReq ? mem[memAddr] : ~mem[memAddr];
endmodule : flash_array_model

// ### tb_top.sv
/*
 * Self-checking bench: read, unlock, erase, page write, buffer clear and rewrite.
 * Assumes the map header and the flash array model beside the controller.
 */
`timescale 1ns/1ps
`include "flash_iap_map.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic [12:0] memAddr;
	logic [15:0] memReadData, memProgData;
	logic memReadReq, memEraseReq, memProgReq, cpuStall, irq;
	int n_fail = 0, comparisons = 0, progCnt = 0, eraseCnt = 0, rdCnt = 0, rdLen = 0, lastLen = 0;
	always #2.5 clk = ~clk;
	flash_iap_read_write_control #(.EW_CLKS(8), .UNLOCK_CLKS(40)) i_dut (.clk, .rst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .memAddr, .memReadReq, .memReadData, .memEraseReq,
		.memProgReq, .memProgData, .cpuStall, .irq);
	flash_array_model i_mem (.clk, .memAddr, .memReadReq, .memEraseReq, .memProgReq,
		.memProgData, .memReadData);
	always @(posedge clk) begin
		if (memProgReq) progCnt++;
		if (memEraseReq) eraseCnt++;
		if (memReadReq) rdLen++;
		else if (rdLen != 0) begin
			lastLen = rdLen;
			rdLen = 0;
			rdCnt++;
		end
	end
	task finish_test;
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		n = 0;
		tb = 0;
		// let one edge pass so the last call's release is not overwritten in its own time step
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
			n++;
			if (n > 50) check("write wait", 0, 1);
			if (n > 50) finish_test();
		end
	endtask : axw
	task axr(input logic [7:0] a);
		int n;
		logic ta, tb;
		n = 0;
		tb = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_arready;
			tb = s_axi_rvalid;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tb) s_axi_rready <= 1'b0;
			n++;
			if (n > 50) check("read wait", 0, 1);
			if (n > 50) finish_test();
		end
	endtask : axr
	// polls a control bit; each poll is a full bus read, so the bound is in reads
	task poll(input int b, input logic v);
		int n;
		n = 0;
		axr(`FIAP_CTRL_OFS);
		while (rd[b] !== v) begin
			axr(`FIAP_CTRL_OFS);
			n++;
			if (n > 200) check("poll wait", 0, 1);
			if (n > 200) finish_test();
		end
	endtask : poll
	task chk_irq(input logic exp);
		@(negedge clk);
		check("irq", irq, exp);
		@(posedge clk);
	endtask : chk_irq
	task t_read;
		i_mem.mem[13'h0a7] = 16'hc35a;
		axw(`FIAP_ADDRL_OFS, 32'ha7);
		axw(`FIAP_ADDRH_OFS, 32'h0);
		axw(`FIAP_IRQ_MASK_OFS, 32'h1);
		axw(`FIAP_CTRL_OFS, 32'h13);
		repeat (20) @(posedge clk);
		check("read without enable", rdCnt, 0);
		axw(`FIAP_CTRL_OFS, 32'h1b);
		poll(4, 1'b0);
		check("read window", lastLen, `FIAP_READ_CLKS);
		check("reads done", rdCnt, 1);
		axr(`FIAP_DATAL_OFS);
		check("data low", rd[7:0], 8'h5a);
		axr(`FIAP_DATAH_OFS);
		check("data high", rd[7:0], 8'hc3);
		chk_irq(1'b1);
		axw(`FIAP_IRQ_STATUS_OFS, 32'h1);
		chk_irq(1'b0);
		axr(8'h40);
		check("unmapped", resp, `FIAP_RESP_SLVERR);
	endtask : t_read
	task t_erase;
		axw(`FIAP_CTRL_OFS, 32'h21);
		repeat (30) @(posedge clk);
		check("erase while locked", eraseCnt, 0);
		axw(`FIAP_CTRL_OFS, 32'h46);
		axw(`FIAP_KEY1_OFS, {16'h0, `FIAP_KEY1});
		axw(`FIAP_KEY2_OFS, {16'h0, `FIAP_KEY2});
		axw(`FIAP_KEY3_OFS, {16'h0, `FIAP_KEY3});
		poll(6, 1'b0);
		check("unlocked", rd[7], 1'b1);
		axw(`FIAP_ADDRL_OFS, 32'h67);
		axw(`FIAP_CTRL_OFS, 32'ha1);
		poll(5, 1'b0);
		check("erase pulses", eraseCnt, 1);
		for (int i = 0; i < 32; i++) check("erased", i_mem.mem[{8'h03, i[4:0]}], 16'hffff);
		check("next page", i_mem.mem[13'h080], 16'h1234);
	endtask : t_erase
	task t_write;
		axw(`FIAP_CTRL_OFS, 32'h80);
		axw(`FIAP_ADDRL_OFS, 32'h60);
		axw(`FIAP_DATAL_OFS, 32'h00);
		axw(`FIAP_DATAH_OFS, 32'h00);
		axw(`FIAP_CTRL_OFS, 32'h180);
		axw(`FIAP_ADDRL_OFS, 32'h60);
		for (int i = 0; i < 33; i++) begin
			axw(`FIAP_DATAL_OFS, i);
			axw(`FIAP_DATAH_OFS, 32'h5c);
		end
		progCnt = 0;
		axw(`FIAP_CTRL_OFS, 32'ha0);
		poll(5, 1'b0);
		check("program pulses", progCnt, 32);
		for (int i = 0; i < 31; i++) check("word", i_mem.mem[{8'h03, i[4:0]}], {8'h5c, i[7:0]});
		check("last word kept", i_mem.mem[13'h07f], 16'h5c20);
		check("page bound", i_mem.mem[13'h080], 16'h1234);
		axw(`FIAP_CTRL_OFS, 32'h180);
		axw(`FIAP_ADDRL_OFS, 32'h65);
		axw(`FIAP_DATAL_OFS, 32'h05);
		axw(`FIAP_DATAH_OFS, 32'h1c);
		progCnt = 0;
		axw(`FIAP_CTRL_OFS, 32'ha0);
		poll(5, 1'b0);
		check("cleared buffer", progCnt, 1);
		check("rewrite", i_mem.mem[13'h065], 16'h1c05);
		axw(`FIAP_CTRL_OFS, 32'h00);
		axw(`FIAP_CTRL_OFS, 32'h21);
		repeat (30) @(posedge clk);
		check("erase after disable", eraseCnt, 1);
	endtask : t_write
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_read();
		t_erase();
		t_write();
		finish_test();
	end
endmodule : tb_top
